//--- power_state_sequencer_tb.sv
// Self-checking bench of the power state sequencer
module power_state_sequencer_tb
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE = 4;
  logic        clk, rst_n, stby, srst, tclr, cal_keep, flag;
  logic [1:0]  pwm_in, pwm_bit, gd;
  logic [31:0] r;
  pss_mon_t    want, mon_raw;
  pss_state_t  state;
  pss_ctl_t    ctl;
  int          bad_count, n_compared, n;
  // ****
  // Clock, partner and design
  // ****
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  pss_mon_model u_mon (.clk(clk), .want(want), .mon_raw(mon_raw));
  pss_sequencer #(.WAKE_CYCLES(WAKE)) DUT (.clk(clk), .rst_n(rst_n), .mon_raw(mon_raw),
    .standby_request_bit(stby), .soft_reset_bit(srst), .ter_clear(tclr),
    .channel_pwm_input(pwm_in), .channel_pwm_control_bit(pwm_bit), .state(state),
    .ctl(ctl), .cal_keep(cal_keep), .high_side_gate_drive(gd),
    .transmission_error_flag(flag));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Settle, then compare against the priority model
  task automatic check_all(input int k);
    int s, sw, dig;
    repeat (k) @(posedge clk);
    @(negedge clk);
    s = (!want.main_supply_ok || !want.enable_undervoltage_pin) ? 0 :
        want.limp_home_input ? 2 : stby ? 1 : 3;
    dig = want.digital_supply_ok;
    sw = (s >= 2) && want.gate_driver_supply && want.internal_ldo_output && dig;
    chk(state, s[7:0]);
    chk({ctl.ldo_enable, ctl.switch_enable, ctl.spi_read_ok, ctl.spi_write_ok},
        {s != 0, sw[0], s != 0 && dig != 0, (s == 1 || s == 3) && dig != 0});
    chk(gd, {2{sw[0] && s == 3}} & (pwm_in | pwm_bit));
    chk(ctl.reg_reset, s == 0 || dig == 0);
    chk(cal_keep, 1'b0);
  endtask : check_all
  // ****
  // Scenarios
  // ****
  initial
  begin
    {rst_n, stby, srst, tclr, pwm_in, pwm_bit} = '0;
    want = pss_mon_t'(6'h3e);
    bad_count = 0;
    n_compared = 0;
    n = $urandom(22);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    check_all(20);
    chk(flag, 1'b1);
    @(posedge clk) tclr <= 1'b1;
    @(posedge clk) tclr <= 1'b0;
    @(negedge clk) chk(flag, 1'b0);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(negedge clk) chk({ctl.reg_reset, cal_keep}, 2'h3);
    check_all(5);
    chk(flag, 1'b1);
    @(posedge clk) want <= pss_mon_t'(6'h2e);
    repeat (2) @(posedge clk);
    want <= pss_mon_t'(6'h3e);
    repeat (12)
    begin
      @(negedge clk);
      chk(state, PSS_ACTIVE);
    end
    @(posedge clk) want <= pss_mon_t'(6'h1e);
    check_all(20);
    @(posedge clk) want <= pss_mon_t'(6'h3e);
    n = 0;
    while (state !== PSS_ACTIVE && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 60)
      bad_count++;
    chk(n > WAKE + 4, 1'b1);
    chk(n <= WAKE + 8, 1'b1);
    repeat (40)
    begin
      @(posedge clk);
      r = $urandom;
      want <= pss_mon_t'({r[0] | r[1], r[2] | r[3], r[4] | r[9], r[5] | r[10],
                          r[6] | r[11], r[7] & r[12]});
      stby <= r[8] & r[13];
      pwm_in <= r[15:14];
      pwm_bit <= r[17:16];
      check_all(20);
    end
    give_verdict();
  end
endmodule : power_state_sequencer_tb

//--- pss_mon_model.sv
// Supply monitor and host pin model
module pss_mon_model
  import pss_pkg::*;
(
  input  wire logic     clk,
  input  wire pss_mon_t want,
  output pss_mon_t      mon_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Levels move just after an edge
  // ****
  always_ff @(posedge clk)
    mon_raw <= want;
endmodule : pss_mon_model

//--- pss_pkg.sv
// Types of the power state sequencer
package pss_pkg;
  typedef enum logic [1:0] {
    PSS_SLEEP,
    PSS_IDLE,
    PSS_LIMP,
    PSS_ACTIVE
  } pss_state_t;

  typedef struct packed {
    logic main_supply_ok;
    logic enable_undervoltage_pin;
    logic internal_ldo_output;
    logic gate_driver_supply;
    logic digital_supply_ok;
    logic limp_home_input;
  } pss_mon_t;

  typedef struct packed {
    logic ldo_enable;
    logic switch_enable;
    logic spi_read_ok;
    logic spi_write_ok;
    logic reg_reset;
  } pss_ctl_t;
endpackage : pss_pkg

//--- pss_regs.svh
// Constants of the power state sequencer
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_FILT_CYCLES 2'h3
`define PSS_FILT_W 2
`define PSS_WAKE_NS 10000
`define PSS_CLK_NS 100
`define PSS_WAKE_W 8
`endif

//--- pss_sequencer.sv
// Power state sequencer for a dual-channel LED buck controller
// Function
// - Exactly four power states, exactly one held at any time.
// - Transitions use supply, pin, limp and standby inputs filtered three cycles.
// - Power-up starts only after main supply monitor reports valid.
// - First power-up enters sleep, outputs off, registers reset.
// - Sleep to active waits a parameterised wake-up interval before switching.
// - Idle keeps regulator on and suppresses all switching.
// - Idle with valid digital supply keeps registers and SPI working.
// - Digital undervoltage blocks gate drive, rejects SPI, resets registers.
// - Gate-driver or LDO undervoltage stops switching, keeps register contents.
// - Enable pin undervoltage stops LDO, switching, SPI, resets registers.
// - Entering limp home resets registers; SPI then allows reads only.
// - Active channel switches only when its PWM input or bit high.
// - Soft reset bit restores writable registers, keeps calibration result.
// - Any reset source sets the transmission error flag.
`include "pss_regs.svh"
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int WAKE_CYCLES = `PSS_WAKE_NS / `PSS_CLK_NS
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire pss_mon_t   mon_raw,
  input  wire logic       standby_request_bit,
  input  wire logic       soft_reset_bit,
  input  wire logic       ter_clear,
  input  wire logic [1:0] channel_pwm_input,
  input  wire logic [1:0] channel_pwm_control_bit,
  output pss_state_t      state,
  output pss_ctl_t        ctl,
  output logic            cal_keep,
  output logic [1:0]      high_side_gate_drive,
  output logic            transmission_error_flag
);
  // ****************************************
  // Input synchronisers and filters
  // ****************************************
  localparam int NMON = $bits(pss_mon_t);
  logic [NMON-1:0] s1_r, s2_r;
  logic [NMON:0]   filt_in, filt_r, filt_nxt;
  logic [NMON:0][`PSS_FILT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] pwm1_r, pwm2_r;
  pss_mon_t mon;
  logic stby;

  // Standby bit is same-clock: filtered but not synchronised
  assign filt_in = {standby_request_bit, s2_r};

  always_comb
  begin
    for (int i = 0; i <= NMON; i++)
    begin
      filt_nxt[i] = filt_r[i];
      cnt_nxt[i] = '0;
      if (filt_in[i] != filt_r[i])
      begin
        cnt_nxt[i] = cnt_r[i] + 2'h1;
        if (cnt_r[i] == `PSS_FILT_CYCLES - 2'h1)
        begin
          filt_nxt[i] = filt_in[i];
          cnt_nxt[i] = '0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      filt_r <= '0;
      cnt_r <= '0;
      pwm1_r <= '0;
      pwm2_r <= '0;
    end
    else
    begin
      s1_r <= mon_raw;
      s2_r <= s1_r;
      filt_r <= filt_nxt;
      cnt_r <= cnt_nxt;
      pwm1_r <= channel_pwm_input;
      pwm2_r <= pwm1_r;
    end
  end

  assign mon = pss_mon_t'(filt_r[NMON-1:0]);
  assign stby = filt_r[NMON];

  // ****************************************
  // Power state machine
  // ****************************************
  pss_state_t state_r, state_nxt;
  logic [`PSS_WAKE_W-1:0] wake_r, wake_nxt;
  logic regrst_nxt, ter_nxt, ter_r, regrst_r;
  logic hard_nxt, cal_nxt, cal_r;
  logic drv_ok;

  always_comb
  begin
    state_nxt = state_r;
    wake_nxt = wake_r;
    if (!mon.main_supply_ok || !mon.enable_undervoltage_pin)
    begin
      state_nxt = PSS_SLEEP;
      wake_nxt = '0;
    end
    else
    begin
      case (state_r)
        PSS_SLEEP:
        begin
          if (mon.limp_home_input)
            state_nxt = PSS_LIMP;
          else if (stby)
            state_nxt = PSS_IDLE;
          else if (wake_r == `PSS_WAKE_W'(WAKE_CYCLES))
            state_nxt = PSS_ACTIVE;
          else
            wake_nxt = wake_r + `PSS_WAKE_W'(1);
        end
        PSS_IDLE:
        begin
          if (mon.limp_home_input)
            state_nxt = PSS_LIMP;
          else if (!stby)
            state_nxt = PSS_ACTIVE;
        end
        PSS_LIMP:
        begin
          if (!mon.limp_home_input)
            state_nxt = stby ? PSS_IDLE : PSS_ACTIVE;
        end
        PSS_ACTIVE:
        begin
          if (mon.limp_home_input)
            state_nxt = PSS_LIMP;
          else if (stby)
            state_nxt = PSS_IDLE;
        end
        default: state_nxt = PSS_SLEEP;
      endcase
    end
    // Merged register default-load
    hard_nxt = state_nxt == PSS_SLEEP || !mon.digital_supply_ok
      || (state_nxt == PSS_LIMP && state_r != PSS_LIMP);
    regrst_nxt = hard_nxt || soft_reset_bit;
    // Calibration spared only when the load is soft reset alone
    cal_nxt = soft_reset_bit && !hard_nxt;
    ter_nxt = regrst_r | (ter_r & ~ter_clear);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= PSS_SLEEP;
      wake_r <= '0;
      regrst_r <= 1'b1;
      ter_r <= 1'b1;
      cal_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wake_r <= wake_nxt;
      regrst_r <= regrst_nxt;
      ter_r <= ter_nxt;
      cal_r <= cal_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign drv_ok = mon.gate_driver_supply && mon.internal_ldo_output
    && mon.digital_supply_ok;
  assign state = state_r;
  assign ctl.ldo_enable = state_r != PSS_SLEEP;
  assign ctl.switch_enable = drv_ok && (state_r == PSS_ACTIVE || state_r == PSS_LIMP);
  assign ctl.spi_read_ok = state_r != PSS_SLEEP && mon.digital_supply_ok;
  assign ctl.spi_write_ok = ctl.spi_read_ok && state_r != PSS_LIMP;
  assign ctl.reg_reset = regrst_r;
  assign cal_keep = cal_r;
  assign transmission_error_flag = ter_r;
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      high_side_gate_drive[c] = state_r == PSS_ACTIVE && drv_ok
        && (pwm2_r[c] || channel_pwm_control_bit[c]);
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_limp_entry;
    state_r != PSS_LIMP ##1 state_r == PSS_LIMP;
  endsequence
  sequence s_sleep_to_active;
    state_r == PSS_SLEEP ##1 state_r == PSS_ACTIVE;
  endsequence

  a_idle_no_switch: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == PSS_IDLE |-> high_side_gate_drive == 2'h0 && !ctl.switch_enable)
    else $error("switching in idle");
  a_en_uv_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    !mon.enable_undervoltage_pin |=> state_r == PSS_SLEEP && !ctl.spi_read_ok)
    else $error("enable undervoltage not sleeping");
  a_dig_uv_block: assert property (@(posedge clk) disable iff (!rst_n)
    !mon.digital_supply_ok |-> high_side_gate_drive == 2'h0 ##1 regrst_r)
    else $error("digital undervoltage not blocking");
  a_limp_read_only: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == PSS_LIMP |-> !ctl.spi_write_ok)
    else $error("write in limp home");
  a_limp_entry_rst: assert property (@(posedge clk) disable iff (!rst_n)
    s_limp_entry |-> regrst_r)
    else $error("limp entry no reset");
  a_ter_after_rst: assert property (@(posedge clk) disable iff (!rst_n)
    regrst_r |=> transmission_error_flag)
    else $error("error flag not set");
  a_wake_delay: assert property (@(posedge clk) disable iff (!rst_n)
    s_sleep_to_active |-> $past(wake_r) == `PSS_WAKE_W'(WAKE_CYCLES))
    else $error("wake interval short");
  a_drv_uv_stop: assert property (@(posedge clk) disable iff (!rst_n)
    !mon.gate_driver_supply |-> high_side_gate_drive == 2'h0)
    else $error("driver on under undervoltage");
  a_pwm_gate: assert property (@(posedge clk) disable iff (!rst_n)
    high_side_gate_drive[0] |-> pwm2_r[0] || channel_pwm_control_bit[0])
    else $error("switching without pwm");
  a_soft_rst_load: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_bit |=> ctl.reg_reset)
    else $error("soft reset not loading defaults");
endmodule : pss_sequencer
